// >>> phy_power_ctrl_status_regs.sv
/*
  register group for the integrated phy: timers, soft reset, basic control,
  basic status, identifier low, and the energy detect low power sequencer.
  assumes a single AHB-Lite master, phy status inputs synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module phy_power_ctrl_status_regs #(
  parameter int unsigned WAKE_UNIT  = phy_regs_pkg::WAKE_UNIT_CYC,
  parameter int unsigned SLEEP_UNIT = phy_regs_pkg::SLEEP_UNIT_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             energy_present,
  input  wire logic             link_up,
  input  wire logic             an_complete,
  output var phy_regs_pkg::phy_ctrl_s phy_ctrl,
  output logic                  phy_reset,
  output logic                  an_restart,
  output logic                  low_power
);

  typedef enum logic [1:0] {PWR_NORMAL, PWR_LOW} pwr_e;

  // write data phase captured from address phase
  logic        wr_pend, next_wr_pend;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;

  logic [15:0] sleep_wake_timer, next_sleep_wake_timer;
  logic [15:0] ctrl, next_ctrl;
  logic [7:0]  pwr_mgmt, next_pwr_mgmt;
  logic        next_phy_reset;
  logic        next_an_restart;

  pwr_e        pwr, next_pwr;
  logic [31:0] unit_cnt, next_unit_cnt;
  logic [7:0]  unit_num, next_unit_num;

  function automatic logic [31:0] unit_len(input logic lowp);
    unit_len = lowp ? WAKE_UNIT : SLEEP_UNIT;
  endfunction : unit_len

  logic addr_ok;
  logic rd_req;
  logic [15:0] status_word;
  logic energy_mode;
  logic watched;
  logic ctrl_wr;

  assign addr_ok     = hsel && hready && htrans[1];
  assign rd_req      = addr_ok && !hwrite;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign energy_mode = (pwr_mgmt[1:0] == phy_regs_pkg::PM_ENERGY_DETECT);
  // hsize not decoded: only whole-word single transfers reach this block
  assign ctrl_wr     = wr_pend && (wr_addr == phy_regs_pkg::IDX_BASIC_CTRL);

  always_comb
  begin
    status_word = phy_regs_pkg::STAT_FIXED;
    status_word[phy_regs_pkg::SB_AN_DONE] = an_complete;
    status_word[phy_regs_pkg::SB_LINK] = link_up;
  end

  // bus slave: zero wait, reads registered from address phase
  always_comb
  begin
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[9:2] : wr_addr;
    next_hrdata  = 32'h0000_0000;
    if (rd_req)
    begin
      unique case (haddr[9:2])
        phy_regs_pkg::IDX_SLEEP_WAKE: next_hrdata = {16'h0000, sleep_wake_timer};
        phy_regs_pkg::IDX_BASIC_CTRL: next_hrdata = {16'h0000, ctrl};
        phy_regs_pkg::IDX_BASIC_STAT: next_hrdata = {16'h0000, status_word};
        phy_regs_pkg::IDX_IDENT_LOW:  next_hrdata = {16'h0000, phy_regs_pkg::IDENT_LOW_DEF};
        phy_regs_pkg::IDX_PWR_MGMT:   next_hrdata = {24'h000000, pwr_mgmt};
        phy_regs_pkg::IDX_PHY_STATE:  next_hrdata = {31'h0, pwr == PWR_LOW};
        default:                      next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // register writes; soft reset and restart are one-cycle pulses
  always_comb
  begin
    next_sleep_wake_timer = sleep_wake_timer;
    next_ctrl             = ctrl;
    next_pwr_mgmt         = pwr_mgmt;
    next_phy_reset        = 1'b0;
    next_an_restart       = 1'b0;
    if (wr_pend)
    begin
      unique case (wr_addr)
        phy_regs_pkg::IDX_SLEEP_WAKE: next_sleep_wake_timer = hwdata[15:0];
        phy_regs_pkg::IDX_SOFT_RESET: next_phy_reset = hwdata[0];
        phy_regs_pkg::IDX_BASIC_CTRL:
        begin
          // single storage serves both the read view and the control outputs
          next_ctrl = hwdata[15:0] & phy_regs_pkg::CTRL_WMASK;
          next_ctrl[phy_regs_pkg::CB_AN_RESTART] = 1'b0;
          next_an_restart = hwdata[phy_regs_pkg::CB_AN_RESTART];
        end
        phy_regs_pkg::IDX_PWR_MGMT:   next_pwr_mgmt = hwdata[7:0];
        default:                      next_ctrl = ctrl;
      endcase
    end
  end

  // energy detect sequencer: counts whole units of steady condition
  always_comb
  begin
    next_pwr      = pwr;
    next_unit_cnt = unit_cnt;
    next_unit_num = unit_num;
    // in low power wait for energy, in normal wait for silence
    watched = (pwr == PWR_LOW) ? energy_present : !energy_present;
    if (!energy_mode)
    begin
      next_pwr      = PWR_NORMAL;
      next_unit_cnt = 32'h0;
      next_unit_num = 8'h00;
    end
    else if (!watched)
    begin
      next_unit_cnt = 32'h0;
      next_unit_num = 8'h00;
    end
    else if (unit_cnt == unit_len(pwr == PWR_LOW) - 32'h1)
    begin
      next_unit_cnt = 32'h0;
      next_unit_num = unit_num + 8'h01;
      if (pwr == PWR_NORMAL && unit_num + 8'h01 >= sleep_wake_timer[7:0])
      begin
        next_pwr      = PWR_LOW;
        next_unit_num = 8'h00;
      end
      else if (pwr == PWR_LOW && unit_num + 8'h01 >= sleep_wake_timer[15:8])
      begin
        next_unit_num = 8'h00;
        if (pwr_mgmt[phy_regs_pkg::PM_AUTO_WAKE])
          next_pwr = PWR_NORMAL;
      end
    end
    else
      next_unit_cnt = unit_cnt + 32'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend          <= 1'b0;
      wr_addr          <= 8'h00;
      hrdata           <= 32'h0000_0000;
      sleep_wake_timer <= {phy_regs_pkg::WAKE_RST, phy_regs_pkg::SLEEP_RST};
      ctrl             <= phy_regs_pkg::CTRL_RST;
      pwr_mgmt         <= 8'h00;
      phy_reset        <= 1'b0;
      an_restart       <= 1'b0;
      pwr              <= PWR_NORMAL;
      unit_cnt         <= 32'h0;
      unit_num         <= 8'h00;
    end
    else
    begin
      wr_pend          <= next_wr_pend;
      wr_addr          <= next_wr_addr;
      hrdata           <= next_hrdata;
      sleep_wake_timer <= next_sleep_wake_timer;
      ctrl             <= next_ctrl;
      pwr_mgmt         <= next_pwr_mgmt;
      phy_reset        <= next_phy_reset;
      an_restart       <= next_an_restart;
      pwr              <= next_pwr;
      unit_cnt         <= next_unit_cnt;
      unit_num         <= next_unit_num;
    end
  end

  assign low_power = (pwr == PWR_LOW);

  // control outputs straight from storage
  always_comb
  begin
    phy_ctrl.loopback      = ctrl[phy_regs_pkg::CB_LOOPBACK];
    phy_ctrl.force_100     = ctrl[phy_regs_pkg::CB_FORCE100];
    phy_ctrl.an_enable     = ctrl[phy_regs_pkg::CB_AN_EN];
    phy_ctrl.force_full    = ctrl[phy_regs_pkg::CB_FORCE_FD];
    phy_ctrl.xover_alg     = ctrl[phy_regs_pkg::CB_XOVER_ALG];
    phy_ctrl.force_cross   = ctrl[phy_regs_pkg::CB_FORCE_X];
    phy_ctrl.xover_disable = ctrl[phy_regs_pkg::CB_XOVER_DIS];
    phy_ctrl.tx_disable    = ctrl[phy_regs_pkg::CB_TX_DIS];
    phy_ctrl.led_off       = ctrl[phy_regs_pkg::CB_LED_OFF];
  end

  // assertions
  property p_soft_reset;
    @(posedge clk) disable iff (rst)
      (wr_pend && wr_addr == phy_regs_pkg::IDX_SOFT_RESET && hwdata[0]) |=> phy_reset ##1 !phy_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse wrong");

  property p_restart;
    @(posedge clk) disable iff (rst)
      (wr_pend && wr_addr == phy_regs_pkg::IDX_BASIC_CTRL && hwdata[9]) |=> an_restart && !ctrl[9];
  endproperty
  a_restart: assert property (p_restart) else $error("restart not pulsed");

  property p_status_fixed;
    @(posedge clk) disable iff (rst)
      rd_req && haddr[9:2] == phy_regs_pkg::IDX_BASIC_STAT |=>
        hrdata[15:11] == 5'h0F && hrdata[6] == 1'b0 && hrdata[3] && !hrdata[1];
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status constants wrong");

  property p_link;
    @(posedge clk) disable iff (rst)
      rd_req && haddr[9:2] == phy_regs_pkg::IDX_BASIC_STAT |=> hrdata[2] == $past(link_up);
  endproperty
  a_link: assert property (p_link) else $error("link bit wrong");

  property p_an_done;
    @(posedge clk) disable iff (rst)
      rd_req && haddr[9:2] == phy_regs_pkg::IDX_BASIC_STAT |=> hrdata[5] == $past(an_complete);
  endproperty
  a_an_done: assert property (p_an_done) else $error("an complete bit wrong");

  property p_ident;
    @(posedge clk) disable iff (rst)
      rd_req && haddr[9:2] == phy_regs_pkg::IDX_IDENT_LOW |=> hrdata[15:0] == phy_regs_pkg::IDENT_LOW_DEF;
  endproperty
  a_ident: assert property (p_ident) else $error("identifier wrong");

  property p_mode_only;
    @(posedge clk) disable iff (rst)
      !energy_mode |=> !low_power;
  endproperty
  a_mode_only: assert property (p_mode_only) else $error("low power outside mode");

  property p_no_auto_wake;
    @(posedge clk) disable iff (rst)
      low_power && !pwr_mgmt[7] && energy_mode |=> low_power;
  endproperty
  a_no_auto_wake: assert property (p_no_auto_wake) else $error("woke without enable");

  property p_sleep_needs_silence;
    @(posedge clk) disable iff (rst)
      $rose(low_power) |-> !$past(energy_present);
  endproperty
  a_sleep_needs_silence: assert property (p_sleep_needs_silence) else $error("slept with energy");

  property p_wake_needs_energy;
    @(posedge clk) disable iff (rst)
      $fell(low_power) && $past(energy_mode) |-> $past(energy_present);
  endproperty
  a_wake_needs_energy: assert property (p_wake_needs_energy) else $error("woke without energy");

  // each control output must follow the written word one cycle later
  property p_loopback;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.loopback == $past(hwdata[phy_regs_pkg::CB_LOOPBACK]);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback bit wrong");

  property p_force_100;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.force_100 == $past(hwdata[phy_regs_pkg::CB_FORCE100]);
  endproperty
  a_force_100: assert property (p_force_100) else $error("speed bit wrong");

  property p_an_enable;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.an_enable == $past(hwdata[phy_regs_pkg::CB_AN_EN]);
  endproperty
  a_an_enable: assert property (p_an_enable) else $error("autoneg enable bit wrong");

  property p_force_full;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.force_full == $past(hwdata[phy_regs_pkg::CB_FORCE_FD]);
  endproperty
  a_force_full: assert property (p_force_full) else $error("duplex bit wrong");

  property p_xover_alg;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.xover_alg == $past(hwdata[phy_regs_pkg::CB_XOVER_ALG]);
  endproperty
  a_xover_alg: assert property (p_xover_alg) else $error("crossover algorithm bit wrong");

  property p_force_cross;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.force_cross == $past(hwdata[phy_regs_pkg::CB_FORCE_X]);
  endproperty
  a_force_cross: assert property (p_force_cross) else $error("forced crossover bit wrong");

  property p_xover_disable;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.xover_disable == $past(hwdata[phy_regs_pkg::CB_XOVER_DIS]);
  endproperty
  a_xover_disable: assert property (p_xover_disable) else $error("crossover disable bit wrong");

  property p_tx_disable;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.tx_disable == $past(hwdata[phy_regs_pkg::CB_TX_DIS]);
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("transmit disable bit wrong");

  property p_led_off;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> phy_ctrl.led_off == $past(hwdata[phy_regs_pkg::CB_LED_OFF]);
  endproperty
  a_led_off: assert property (p_led_off) else $error("led disable bit wrong");

  property p_restart_quiet;
    @(posedge clk) disable iff (rst)
      !ctrl_wr |=> !an_restart;
  endproperty
  a_restart_quiet: assert property (p_restart_quiet) else $error("restart without write");

  property p_reset_quiet;
    @(posedge clk) disable iff (rst)
      !(wr_pend && wr_addr == phy_regs_pkg::IDX_SOFT_RESET) |=> !phy_reset;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("phy reset without write");

  // read data stands for its data phase only
  property p_read_idle;
    @(posedge clk) disable iff (rst)
      !rd_req |=> hrdata == 32'h0000_0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside data phase");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (rst)
      ctrl_wr |=> !ctrl[15] && ctrl[7:6] == 2'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bits set");

  c_sleep: cover property (@(posedge clk) disable iff (rst) $rose(low_power));
  c_restart: cover property (@(posedge clk) disable iff (rst) an_restart);
  c_ctrl_write: cover property (@(posedge clk) disable iff (rst) ctrl_wr);
  c_wake: cover property (@(posedge clk) disable iff (rst) $fell(low_power) && energy_mode);
  c_reset: cover property (@(posedge clk) disable iff (rst) phy_reset);

endmodule : phy_power_ctrl_status_regs

`default_nettype wire

// >>> phy_regs_pkg.sv
/*
  package for the phy power, control and status register group:
  register word indices, field positions, reset values, timing constants.
  assumes a 250 MHz device clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none

package phy_regs_pkg;

  localparam int unsigned CLK_MHZ = 250;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_SLEEP_WAKE = 8'hD6;
  localparam logic [7:0] IDX_SOFT_RESET = 8'hD8;
  localparam logic [7:0] IDX_BASIC_CTRL = 8'hE4;
  localparam logic [7:0] IDX_BASIC_STAT = 8'hE6;
  localparam logic [7:0] IDX_IDENT_LOW  = 8'hE8;
  localparam logic [7:0] IDX_PWR_MGMT   = 8'hF0;
  localparam logic [7:0] IDX_PHY_STATE  = 8'hF2;

  // timer fields
  localparam int unsigned WAKE_LSB  = 8;
  localparam int unsigned SLEEP_LSB = 0;
  localparam logic [7:0]  WAKE_RST  = 8'h08;
  localparam logic [7:0]  SLEEP_RST = 8'h0C;

  // control bits
  localparam int unsigned CB_LOOPBACK  = 14;
  localparam int unsigned CB_FORCE100  = 13;
  localparam int unsigned CB_AN_EN     = 12;
  localparam int unsigned CB_AN_RESTART = 9;
  localparam int unsigned CB_FORCE_FD  = 8;
  localparam int unsigned CB_XOVER_ALG = 5;
  localparam int unsigned CB_FORCE_X   = 4;
  localparam int unsigned CB_XOVER_DIS = 3;
  localparam int unsigned CB_TX_DIS    = 1;
  localparam int unsigned CB_LED_OFF   = 0;
  // writable mask and reset value of basic control
  localparam logic [15:0] CTRL_WMASK = 16'h7F3F;
  localparam logic [15:0] CTRL_RST   = 16'h3120;

  // status: fixed capability bits 14..11 and bit 3
  localparam logic [15:0] STAT_FIXED = 16'h7808;
  localparam int unsigned SB_AN_DONE = 5;
  localparam int unsigned SB_LINK    = 2;

  // power management mode field
  localparam logic [1:0] PM_ENERGY_DETECT = 2'h1;
  localparam int unsigned PM_AUTO_WAKE = 7;

  // arbitrary identifier value
  localparam logic [15:0] IDENT_LOW_DEF = 16'h0A5C;

  // time units
  localparam int unsigned WAKE_UNIT_MS  = 16;
  localparam int unsigned SLEEP_UNIT_MS = 1000;
  localparam int unsigned WAKE_UNIT_CYC  = WAKE_UNIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic force_full;
    logic xover_alg;
    logic force_cross;
    logic xover_disable;
    logic tx_disable;
    logic led_off;
  } phy_ctrl_s;

endpackage : phy_regs_pkg

`default_nettype wire

// >>> phy_power_ctrl_status_regs_tb.sv
/*
  self-checking bench for the phy register group: drives the AHB-Lite port
  and the phy status inputs, checks registers, pulses and the sleep timers.
  assumes timer units shortened by parameter; waits on hready for any slave.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_power_ctrl_status_regs_tb;
  localparam int unsigned WU = 4;
  localparam int unsigned SU = 10;
  logic                    clk;
  logic                    rst;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic                    energy_present;
  logic                    link_up;
  logic                    an_complete;
  phy_regs_pkg::phy_ctrl_s phy_ctrl;
  logic                    phy_reset;
  logic                    an_restart;
  logic                    low_power;
  int                      errors;
  int                      num_checks;
  int                      n;

  phy_power_ctrl_status_regs #(.WAKE_UNIT(WU), .SLEEP_UNIT(SU)) DUT (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .energy_present(energy_present), .link_up(link_up), .an_complete(an_complete),
    .phy_ctrl(phy_ctrl), .phy_reset(phy_reset), .an_restart(an_restart), .low_power(low_power)
  );

  always #2 clk = ~clk;

  task end_sim;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // waits for hready at a rising edge; data and response taken at that same edge
  task phase(output logic [31:0] d);
    int   k;
    logic ok;
    k = 0;
    ok = 1'b0;
    while (!ok)
    begin
      @(posedge clk);
      ok = (hreadyout === 1'b1);
      k++;
      if (!ok && k > 50)
      begin
        errors++;
        end_sim();
      end
    end
    d = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : phase

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] dummy;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, a, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    phase(dummy);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    phase(rd);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'b1, d, dummy);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    xfer(a, 1'b0, 32'h0, d);
    chk(d, exp);
  endtask : rd_chk

  // counts one-cycle pulses over a short window after a write
  task pulses(input logic sel, output int c);
    c = 0;
    repeat (4)
    begin
      @(posedge clk);
      if ((sel ? phy_reset : an_restart) === 1'b1)
        c++;
    end
  endtask : pulses

  // cycles until low_power reaches lvl, capped at lim
  task lp_wait(input logic lvl, input int lim, output int c);
    c = 0;
    while (low_power !== lvl && c < lim)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : lp_wait

  task t_reset_values;
    chk({23'h0, phy_ctrl}, 32'h0F0);
    rd_chk(phy_regs_pkg::IDX_SLEEP_WAKE, 32'h080C);
    rd_chk(phy_regs_pkg::IDX_BASIC_CTRL, 32'h3120);
    rd_chk(phy_regs_pkg::IDX_BASIC_STAT, 32'h7808);
    rd_chk(phy_regs_pkg::IDX_IDENT_LOW, {16'h0, phy_regs_pkg::IDENT_LOW_DEF});
    rd_chk(8'h00, 32'h0);
  endtask : t_reset_values

  task t_control;
    wr(phy_regs_pkg::IDX_BASIC_CTRL, 32'hFFFF);
    pulses(1'b0, n);
    chk(n, 1);
    chk({23'h0, phy_ctrl}, 32'h1FF);
    rd_chk(phy_regs_pkg::IDX_BASIC_CTRL, 32'h7D3F);
    wr(phy_regs_pkg::IDX_BASIC_CTRL, 32'h0);
    pulses(1'b0, n);
    chk(n, 0);
    chk({23'h0, phy_ctrl}, 32'h0);
    rd_chk(phy_regs_pkg::IDX_BASIC_CTRL, 32'h0);
  endtask : t_control

  task t_status;
    link_up <= 1'b1;
    an_complete <= 1'b1;
    rd_chk(phy_regs_pkg::IDX_BASIC_STAT, 32'h782C);
    link_up <= 1'b0;
    rd_chk(phy_regs_pkg::IDX_BASIC_STAT, 32'h7828);
    wr(phy_regs_pkg::IDX_BASIC_STAT, 32'h0);
    wr(phy_regs_pkg::IDX_IDENT_LOW, 32'hFFFF);
    rd_chk(phy_regs_pkg::IDX_BASIC_STAT, 32'h7828);
    rd_chk(phy_regs_pkg::IDX_IDENT_LOW, {16'h0, phy_regs_pkg::IDENT_LOW_DEF});
  endtask : t_status

  task t_soft_reset;
    wr(phy_regs_pkg::IDX_SOFT_RESET, 32'h1);
    pulses(1'b1, n);
    chk(n, 1);
    rd_chk(phy_regs_pkg::IDX_SOFT_RESET, 32'h0);
  endtask : t_soft_reset

  task t_timers;
    wr(phy_regs_pkg::IDX_SLEEP_WAKE, 32'h0203);
    rd_chk(phy_regs_pkg::IDX_SLEEP_WAKE, 32'h0203);
    energy_present <= 1'b0;
    lp_wait(1'b1, 60, n);
    chk(n, 60);
    wr(phy_regs_pkg::IDX_PWR_MGMT, 32'h81);
    energy_present <= 1'b1;
    repeat (3) @(posedge clk);
    energy_present <= 1'b0;
    lp_wait(1'b1, 80, n);
    chk(n, 3 * SU);
    rd_chk(phy_regs_pkg::IDX_PHY_STATE, 32'h1);
    rd_chk(phy_regs_pkg::IDX_PWR_MGMT, 32'h81);
    energy_present <= 1'b1;
    lp_wait(1'b0, 40, n);
    chk(n, 2 * WU);
    wr(phy_regs_pkg::IDX_PWR_MGMT, 32'h01);
    energy_present <= 1'b0;
    lp_wait(1'b1, 80, n);
    chk(n, 3 * SU);
    chk(low_power, 1);
    energy_present <= 1'b1;
    lp_wait(1'b0, 40, n);
    chk(n, 40);
  endtask : t_timers

  // reset taken while asleep with a changed control word
  task t_mid_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(low_power, 1'b0);
    chk({23'h0, phy_ctrl}, 32'h0F0);
    rst <= 1'b0;
    rd_chk(phy_regs_pkg::IDX_SLEEP_WAKE, 32'h080C);
    rd_chk(phy_regs_pkg::IDX_PWR_MGMT, 32'h0);
  endtask : t_mid_reset

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    energy_present = 1'b1;
    link_up = 1'b0;
    an_complete = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_control();
    t_status();
    t_soft_reset();
    t_timers();
    t_mid_reset();
    end_sim();
  end
endmodule : phy_power_ctrl_status_regs_tb
`default_nettype wire
